//--- hw/nfh_cycle.sv
/*
 * Pin sequencer: turns one request into a command, address, write or read
 * cycle on the asynchronous flash bus. Assumes io_sync is already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nfh_params.svh"

module nfh_cycle (
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire nfh_pkg::nfh_cyc_t req,
	input wire logic [7:0] io_sync,
	output logic done,
	output logic [7:0] rdata,
	output nfh_pkg::nfh_ctl_t ctl,
	output logic [7:0] io_o,
	output logic io_oe
);

	typedef enum logic [1:0] {NFH_P_IDLE, NFH_P_SETUP, NFH_P_LOW, NFH_P_HIGH} nfh_phase_t;

	// Whole sequencer state
	typedef struct packed {
		nfh_phase_t ph;
		logic [3:0] cnt;
		nfh_pkg::nfh_kind_t kind;
		nfh_pkg::nfh_ctl_t ctl;
		logic [7:0] io;
		logic oe;
		logic done;
		logic [7:0] rd;
	} nfh_cyc_st_t;

	nfh_cyc_st_t s_r; // Registered state
	nfh_cyc_st_t s_nxt; // Next state
	logic is_rd; // Current cycle reads

	// Next-state logic
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		is_rd = (s_r.kind == nfh_pkg::NFH_K_RDATA);
		unique case (s_r.ph)
			NFH_P_IDLE: begin
				if (go) begin
					s_nxt.kind = req.kind;
					s_nxt.ctl.ce_n = 1'b0;
					s_nxt.ctl.cle = (req.kind == nfh_pkg::NFH_K_CMD);
					s_nxt.ctl.ale = (req.kind == nfh_pkg::NFH_K_ADDR);
					s_nxt.io = req.byte_v;
					s_nxt.oe = (req.kind != nfh_pkg::NFH_K_RDATA);
					s_nxt.cnt = 4'(`NFH_SETUP_CYC - 1);
					s_nxt.ph = NFH_P_SETUP;
				end
			end
			NFH_P_SETUP: begin
				if (s_r.cnt == 4'h0) begin
					// Strobe falls; reads wait for the synchroniser as well
					s_nxt.ctl.re_n = !is_rd;
					s_nxt.ctl.we_n = is_rd;
					s_nxt.cnt = is_rd ? 4'(`NFH_RLOW_CYC - 1) : 4'(`NFH_WLOW_CYC - 1);
					s_nxt.ph = NFH_P_LOW;
				end else begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end
			end
			NFH_P_LOW: begin
				if (s_r.cnt == 4'h0) begin
					// Flash latches on the rising write strobe
					s_nxt.ctl.we_n = 1'b1;
					s_nxt.ctl.re_n = 1'b1;
					// One byte per read strobe, low lane only
					if (is_rd) begin
						s_nxt.rd = io_sync;
					end
					s_nxt.cnt = 4'(`NFH_HOLD_CYC - 1);
					s_nxt.ph = NFH_P_HIGH;
				end else begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end
			end
			NFH_P_HIGH: begin
				if (s_r.cnt == 4'h0) begin
					// Latches drop only after the hold time
					s_nxt.ctl.cle = 1'b0;
					s_nxt.ctl.ale = 1'b0;
					s_nxt.oe = 1'b0;
					s_nxt.done = 1'b1;
					s_nxt.ph = NFH_P_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '{ph: NFH_P_IDLE, cnt: 4'h0, kind: nfh_pkg::NFH_K_CMD,
				ctl: '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1},
				io: 8'h00, oe: 1'b0, done: 1'b0, rd: 8'h00};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign done = s_r.done;
	assign rdata = s_r.rd;
	assign ctl = s_r.ctl;
	assign io_o = s_r.io;
	assign io_oe = s_r.oe;

endmodule // nfh_cycle

`default_nettype wire

//--- hw/nfh_host.sv
/*
 * NAND host controller for unique-ID read and set/get features. Software
 * starts an operation through a small register port; the controller drives
 * the flash pins, waits on ready-busy or status polling, and checks the ID.
 * Assumes flash pins are asynchronous to clk; io_i and rb_n are synchronised.
 */
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "nfh_params.svh"

module nfh_host #(
	parameter int TMO_CYC = `NFH_TMO_CYC // Busy timeout, shorten in simulation
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	output nfh_pkg::nfh_ctl_t ctl,
	output logic [7:0] io_o,
	output logic io_oe,
	input wire logic [7:0] io_i,
	input wire logic rb_n
);

	typedef enum logic [3:0] {
		NFH_S_IDLE, NFH_S_CMD, NFH_S_ADR, NFH_S_ADL, NFH_S_WPAR, NFH_S_TWB,
		NFH_S_RBWAIT, NFH_S_STCMD, NFH_S_STRD, NFH_S_RDMODE, NFH_S_RDATA,
		NFH_S_CHECK, NFH_S_RND, NFH_S_CCS, NFH_S_FIN
	} nfh_state_t;

	// Whole controller state
	typedef struct packed {
		nfh_state_t st;
		logic sent; // Cycle requested, awaiting done
		logic go; // Request pulse to sequencer
		nfh_pkg::nfh_cyc_t req;
		logic [4:0] cnt; // Byte index in a copy or parameter set
		logic [3:0] copy; // Identifier copy under test
		logic [1:0] rnd; // Step of the random data read
		logic [19:0] wt; // Wait and timeout counter
		logic bad; // Current copy failed its check
		logic [15:0][7:0] uid;
		logic [3:0][7:0] gf; // Bytes from get features
		logic [3:0][7:0] par; // Bytes for set features
		logic [7:0] faddr;
		nfh_pkg::nfh_op_t op;
		logic poll; // Poll status instead of ready-busy
		logic busy;
		logic done;
		logic ok;
		logic err;
		logic [31:0] rdata;
		logic rb_s1;
		logic rb_s2;
		logic [7:0] io_s1;
		logic [7:0] io_s2;
	} nfh_host_st_t;

	nfh_host_st_t s_r; // Registered state
	nfh_host_st_t s_nxt; // Next state
	logic cyc_done; // Sequencer finished a cycle
	logic [7:0] cyc_rd; // Byte from last read cycle
	logic iss; // This state issues a cycle
	logic adv; // Issued cycle has completed
	nfh_pkg::nfh_cyc_t want; // Cycle this state wants
	logic [7:0] opcode; // Command of current operation
	logic [4:0] last; // Last byte index of a read burst

	// Bus cycle engine
	nfh_cycle nfh_cycle_inst (
		.clk(clk),
		.rst(rst),
		.go(s_r.go),
		.req(s_r.req),
		.io_sync(s_r.io_s2),
		.done(cyc_done),
		.rdata(cyc_rd),
		.ctl(ctl),
		.io_o(io_o),
		.io_oe(io_oe)
	);

	// Sequencing, register port and synchronisers
	always_comb begin
		s_nxt = s_r;
		s_nxt.go = 1'b0;
		// Two-stage synchronisers; stage one feeds stage two only
		s_nxt.rb_s1 = rb_n;
		s_nxt.rb_s2 = s_r.rb_s1;
		s_nxt.io_s1 = io_i;
		s_nxt.io_s2 = s_r.io_s1;
		iss = 1'b0;
		adv = s_r.sent && cyc_done;
		want = '{kind: nfh_pkg::NFH_K_CMD, byte_v: `NFH_CMD_READ_MODE};
		opcode = (s_r.op == nfh_pkg::NFH_OP_UID) ? `NFH_CMD_UID :
			(s_r.op == nfh_pkg::NFH_OP_SETF) ? `NFH_CMD_SET_FEAT : `NFH_CMD_GET_FEAT;
		last = (s_r.op == nfh_pkg::NFH_OP_UID) ? 5'(2 * `NFH_UID_BYTES - 1) : 5'd3;
		unique case (s_r.st)
			NFH_S_IDLE: begin
				// Only start from idle, so flash is idle too
				if (sw_wr && sw_addr == `NFH_REG_CTRL && sw_wdata[`NFH_CTRL_START_BIT]) begin
					s_nxt.op = nfh_pkg::nfh_op_t'(sw_wdata[`NFH_CTRL_OP_LSB +: 2]);
					s_nxt.poll = sw_wdata[`NFH_CTRL_POLL_BIT];
					s_nxt.done = 1'b0;
					s_nxt.ok = 1'b0;
					s_nxt.err = 1'b0;
					s_nxt.cnt = 5'd0;
					s_nxt.copy = 4'h0;
					s_nxt.bad = 1'b0;
					if (nfh_pkg::nfh_op_t'(sw_wdata[`NFH_CTRL_OP_LSB +: 2]) != nfh_pkg::NFH_OP_NONE) begin
						s_nxt.busy = 1'b1;
						s_nxt.st = NFH_S_CMD;
					end
				end
			end
			NFH_S_CMD: begin
				iss = 1'b1;
				want = '{kind: nfh_pkg::NFH_K_CMD, byte_v: opcode};
				if (adv) begin
					s_nxt.st = NFH_S_ADR;
				end
			end
			NFH_S_ADR: begin
				iss = 1'b1;
				// Identifier takes address 00h; features a one-byte address
				want = '{kind: nfh_pkg::NFH_K_ADDR,
					byte_v: (s_r.op == nfh_pkg::NFH_OP_UID) ? `NFH_UID_ADDR : s_r.faddr};
				if (adv) begin
					s_nxt.wt = (s_r.op == nfh_pkg::NFH_OP_SETF) ? 20'(`NFH_ADL_CYC) : 20'(`NFH_WB_CYC);
					s_nxt.st = (s_r.op == nfh_pkg::NFH_OP_SETF) ? NFH_S_ADL : NFH_S_TWB;
				end
			end
			NFH_S_ADL: begin
				// Hold off the first parameter byte
				s_nxt.wt = s_r.wt - 20'd1;
				if (s_r.wt <= 20'd1) begin
					s_nxt.st = NFH_S_WPAR;
				end
			end
			NFH_S_WPAR: begin
				iss = 1'b1;
				want = '{kind: nfh_pkg::NFH_K_WDATA, byte_v: s_r.par[s_r.cnt[1:0]]};
				if (adv) begin
					s_nxt.cnt = s_r.cnt + 5'd1;
					if (s_r.cnt == 5'd3) begin
						// Busy follows the fourth byte
						s_nxt.cnt = 5'd0;
						s_nxt.wt = 20'(`NFH_WB_CYC);
						s_nxt.st = NFH_S_TWB;
					end
				end
			end
			NFH_S_TWB: begin
				// Give the flash time to pull ready-busy low
				s_nxt.wt = s_r.wt - 20'd1;
				if (s_r.wt <= 20'd1) begin
					s_nxt.wt = 20'(TMO_CYC);
					s_nxt.st = s_r.poll ? NFH_S_STCMD : NFH_S_RBWAIT;
				end
			end
			NFH_S_RBWAIT: begin
				// Wait for release; timing-mode change may run longer
				s_nxt.wt = s_r.wt - 20'd1;
				if (s_r.rb_s2) begin
					s_nxt.st = (s_r.op == nfh_pkg::NFH_OP_SETF) ? NFH_S_FIN : NFH_S_RDATA;
				end else if (s_r.wt == 20'd0) begin
					s_nxt.err = 1'b1;
					s_nxt.st = NFH_S_FIN;
				end
			end
			NFH_S_STCMD: begin
				iss = 1'b1;
				want = '{kind: nfh_pkg::NFH_K_CMD, byte_v: `NFH_CMD_STATUS};
				if (adv) begin
					s_nxt.st = NFH_S_STRD;
				end
			end
			NFH_S_STRD: begin
				iss = 1'b1;
				want = '{kind: nfh_pkg::NFH_K_RDATA, byte_v: 8'h00};
				if (adv) begin
					s_nxt.wt = s_r.wt - 20'd1;
					if (cyc_rd[`NFH_STATUS_RDY_BIT]) begin
						s_nxt.st = (s_r.op == nfh_pkg::NFH_OP_SETF) ? NFH_S_FIN : NFH_S_RDMODE;
					end else if (s_r.wt == 20'd0) begin
						s_nxt.err = 1'b1;
						s_nxt.st = NFH_S_FIN;
					end
				end
			end
			NFH_S_RDMODE: begin
				iss = 1'b1;
				// Back from status to data output
				want = '{kind: nfh_pkg::NFH_K_CMD, byte_v: `NFH_CMD_READ_MODE};
				if (adv) begin
					s_nxt.st = NFH_S_RDATA;
				end
			end
			NFH_S_RDATA: begin
				iss = 1'b1;
				want = '{kind: nfh_pkg::NFH_K_RDATA, byte_v: 8'h00};
				if (adv) begin
					s_nxt.cnt = s_r.cnt + 5'd1;
					if (s_r.op == nfh_pkg::NFH_OP_GETF) begin
						s_nxt.gf[s_r.cnt[1:0]] = cyc_rd;
					end else if (!s_r.cnt[4]) begin
						s_nxt.uid[s_r.cnt[3:0]] = cyc_rd;
					end else if ((s_r.uid[s_r.cnt[3:0]] ^ cyc_rd) != `NFH_UID_GOOD) begin
						s_nxt.bad = 1'b1;
					end
					if (s_r.cnt == last) begin
						s_nxt.cnt = 5'd0;
						s_nxt.st = (s_r.op == nfh_pkg::NFH_OP_GETF) ? NFH_S_FIN : NFH_S_CHECK;
					end
				end
			end
			NFH_S_CHECK: begin
				// Accept this copy, or move to the next one
				if (!s_r.bad) begin
					s_nxt.ok = 1'b1;
					s_nxt.st = NFH_S_FIN;
				end else if (s_r.copy == 4'(`NFH_UID_COPIES - 1)) begin
					s_nxt.err = 1'b1;
					s_nxt.st = NFH_S_FIN;
				end else begin
					s_nxt.copy = s_r.copy + 4'h1;
					s_nxt.bad = 1'b0;
					s_nxt.rnd = 2'd0;
					s_nxt.st = NFH_S_RND;
				end
			end
			NFH_S_RND: begin
				iss = 1'b1;
				// 05h, column low, column high, E0h; column = copy * 32
				unique case (s_r.rnd)
					2'd0: want = '{kind: nfh_pkg::NFH_K_CMD, byte_v: `NFH_CMD_RND_READ};
					2'd1: want = '{kind: nfh_pkg::NFH_K_ADDR, byte_v: {s_r.copy[2:0], 5'b00000}};
					2'd2: want = '{kind: nfh_pkg::NFH_K_ADDR, byte_v: {7'b0000000, s_r.copy[3]}};
					2'd3: want = '{kind: nfh_pkg::NFH_K_CMD, byte_v: `NFH_CMD_RND_CONF};
				endcase
				if (adv) begin
					s_nxt.rnd = s_r.rnd + 2'd1;
					if (s_r.rnd == 2'd3) begin
						s_nxt.wt = 20'(`NFH_CCS_CYC);
						s_nxt.st = NFH_S_CCS;
					end
				end
			end
			NFH_S_CCS: begin
				// Column change settle before data
				s_nxt.wt = s_r.wt - 20'd1;
				if (s_r.wt <= 20'd1) begin
					s_nxt.st = NFH_S_RDATA;
				end
			end
			NFH_S_FIN: begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
				s_nxt.st = NFH_S_IDLE;
			end
		endcase
		// One request per issuing visit
		if (iss && !s_r.sent) begin
			s_nxt.go = 1'b1;
			s_nxt.req = want;
			s_nxt.sent = 1'b1;
		end else if (adv) begin
			s_nxt.sent = 1'b0;
		end
		// Configuration writes land only while idle
		if (sw_wr && !s_r.busy) begin
			if (sw_addr == `NFH_REG_FADDR) begin
				s_nxt.faddr = sw_wdata[7:0];
			end
			if (sw_addr == `NFH_REG_PARAM) begin
				s_nxt.par = sw_wdata;
			end
		end
		// Read data valid the cycle after the strobe; unmapped reads zero
		s_nxt.rdata = 32'h00000000;
		if (sw_rd) begin
			unique case (sw_addr)
				`NFH_REG_CTRL: s_nxt.rdata = {28'h0000000, s_r.poll, s_r.op, 1'b0};
				`NFH_REG_FADDR: s_nxt.rdata = {24'h000000, s_r.faddr};
				`NFH_REG_PARAM: s_nxt.rdata = s_r.par;
				`NFH_REG_STATUS: s_nxt.rdata = {28'h0000000, s_r.err, s_r.ok, s_r.done, s_r.busy};
				`NFH_REG_GETDATA: s_nxt.rdata = s_r.gf;
				8'h14: s_nxt.rdata = s_r.uid[3:0];
				8'h18: s_nxt.rdata = s_r.uid[7:4];
				8'h1C: s_nxt.rdata = s_r.uid[11:8];
				8'h20: s_nxt.rdata = s_r.uid[15:12];
				default: s_nxt.rdata = 32'h00000000;
			endcase
		end
	end

	// State register; flash features are held by the flash, not here
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.st <= NFH_S_IDLE;
			s_r.op <= nfh_pkg::NFH_OP_UID;
			s_r.rb_s1 <= 1'b1;
			s_r.rb_s2 <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sw_rdata = s_r.rdata;

endmodule // nfh_host

`default_nettype wire

//--- hw/nfh_params.svh
/*
 * Constants of the NAND feature and unique-ID host controller: command codes,
 * feature addresses, software register offsets, reset values and timing counts.
 * Assumes a 10 MHz controller clock; included by the package and the modules.
 */
// Overview of operation
// - Address 00h follows EDh, then await busy
// - After status polling, issue 00h before reading
// - XOR halves; accept copy if all FFh
// - Random data read 05h-E0h moves to next copy
// - Wait address-to-data delay before parameter bytes
`ifndef NFH_PARAMS_SVH
`define NFH_PARAMS_SVH

// Flash command codes
`define NFH_CMD_READ_MODE 8'h00
`define NFH_CMD_RND_READ 8'h05
`define NFH_CMD_RND_CONF 8'hE0
`define NFH_CMD_STATUS 8'h70
`define NFH_CMD_UID 8'hED
`define NFH_CMD_SET_FEAT 8'hEF
`define NFH_CMD_GET_FEAT 8'hEE
`define NFH_UID_ADDR 8'h00

// Feature addresses
`define NFH_FEAT_TIMING 8'h01
`define NFH_FEAT_DRIVE 8'h80
`define NFH_FEAT_RB_PULL 8'h81
`define NFH_FEAT_ARRAY_MODE 8'h90
`define NFH_ARRAY_NORMAL 8'h00
`define NFH_ARRAY_OTP_OP 8'h01
`define NFH_ARRAY_OTP_PROT 8'h03

// Identifier layout
`define NFH_UID_BYTES 16
`define NFH_UID_COPIES 16
`define NFH_UID_GOOD 8'hFF
`define NFH_STATUS_RDY_BIT 6

// Software register offsets
`define NFH_REG_CTRL 8'h00
`define NFH_REG_FADDR 8'h04
`define NFH_REG_PARAM 8'h08
`define NFH_REG_STATUS 8'h0C
`define NFH_REG_GETDATA 8'h10
`define NFH_REG_UID0 8'h14
`define NFH_CTRL_START_BIT 0
`define NFH_CTRL_OP_LSB 1
`define NFH_CTRL_POLL_BIT 3
`define NFH_RESET_BYTE 8'h00

// Timing, in ns, and derived cycle counts
`define NFH_CLK_NS 100
`define NFH_CEIL_CYC(ns) ((((ns) + `NFH_CLK_NS - 1) / `NFH_CLK_NS) < 1 ? 1 : \
	(((ns) + `NFH_CLK_NS - 1) / `NFH_CLK_NS))
`define NFH_T_SETUP_NS 20
`define NFH_T_WP_NS 12
`define NFH_T_REA_NS 20
`define NFH_T_HOLD_NS 10
`define NFH_T_ADL_NS 70
`define NFH_T_WB_NS 100
`define NFH_T_CCS_NS 100
`define NFH_T_TMO_NS 1000000
`define NFH_SYNC_STAGES 2
`define NFH_SETUP_CYC `NFH_CEIL_CYC(`NFH_T_SETUP_NS)
`define NFH_WLOW_CYC `NFH_CEIL_CYC(`NFH_T_WP_NS)
`define NFH_RLOW_CYC (`NFH_CEIL_CYC(`NFH_T_REA_NS) + `NFH_SYNC_STAGES)
`define NFH_HOLD_CYC `NFH_CEIL_CYC(`NFH_T_HOLD_NS)
`define NFH_ADL_CYC `NFH_CEIL_CYC(`NFH_T_ADL_NS)
`define NFH_WB_CYC `NFH_CEIL_CYC(`NFH_T_WB_NS)
`define NFH_CCS_CYC `NFH_CEIL_CYC(`NFH_T_CCS_NS)
`define NFH_TMO_CYC (`NFH_T_TMO_NS / `NFH_CLK_NS)

`endif

//--- hw/nfh_pkg.sv
/*
 * Types of the NAND feature and unique-ID host controller.
 * Assumes nfh_params.svh is on the include path.
 */
`include "nfh_params.svh"

package nfh_pkg;

	// Kind of one flash bus cycle
	typedef enum logic [1:0] {
		NFH_K_CMD,
		NFH_K_ADDR,
		NFH_K_WDATA,
		NFH_K_RDATA
	} nfh_kind_t;

	// Operation chosen by software
	typedef enum logic [1:0] {
		NFH_OP_UID,
		NFH_OP_SETF,
		NFH_OP_GETF,
		NFH_OP_NONE
	} nfh_op_t;

	// One cycle request to the pin sequencer
	typedef struct packed {
		nfh_kind_t kind;
		logic [7:0] byte_v;
	} nfh_cyc_t;

	// Flash control pins, all driven by the host
	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
	} nfh_ctl_t;

endpackage

//--- sim/nfh_flash_model.sv
/*
 * Behavioural flash target for the host controller: unique-ID readout,
 * set/get features, status output and ready-busy.
 * Assumes the bench resolves the shared data bus from the host output enable.
 */
`timescale 1ns/1ps
`default_nettype none

module nfh_flash_model #(
	parameter int BUSY_NS = 1500 // Array and feature busy time
) (
	input wire nfh_pkg::nfh_ctl_t ctl,
	input wire logic [7:0] io_in,
	input wire logic bad_copy,
	input wire logic hang,
	output logic [7:0] dq,
	output logic rb_n
);
	logic [31:0] feat [4]; // Settings of 01h, 80h, 81h, 90h
	logic [31:0] plast; // Last parameter bytes taken
	logic [7:0] op, lc, fa, lo, hi, last, ob;
	logic [11:0] col;
	logic stat_md;
	int na, np, nrand;
	event go_busy;

	// Power-on state only: no reset input, so settings survive host resets
	initial begin
		foreach (feat[i]) feat[i] = 32'h0;
		{op, lc, fa, lo, hi, last, col, stat_md, plast} = '0;
		rb_n = 1'b1;
		na = 0;
		np = 0;
		nrand = 0;
	end

	// Reserved addresses have no slot
	function automatic int slot(input logic [7:0] a);
		case (a)
			8'h01: return 0;
			8'h80: return 1;
			8'h81: return 2;
			8'h90: return 3;
			default: return -1;
		endcase
	endfunction

	// Byte c of the identifier area; copy 0 can be spoiled on demand
	function automatic logic [7:0] uid(input logic [11:0] c, input logic b);
		logic [7:0] v;
		v = 8'hA0 + {4'h0, c[3:0]};
		if (b && c == 12'h010)
			v = 8'h00;
		else if (c[4])
			v = ~v;
		return v;
	endfunction

	// Output byte for the current mode
	always_comb begin
		if (stat_md)
			ob = {1'b1, rb_n, 6'h00};
		else if (op == 8'hEE)
			ob = (slot(fa) < 0) ? 8'h00 : feat[slot(fa)][8 * col[1:0] +: 8];
		else
			ob = uid(col, bad_copy);
	end

	// Released bus shows the inverse of the last byte, not a held value
	assign dq = (!ctl.ce_n && !ctl.re_n) ? ob : ~last;

	// Busy interval; a hang stretches it past the host timeout
	always begin
		@(go_busy);
		rb_n = 1'b0;
		#(BUSY_NS);
		if (hang)
			#20000;
		rb_n = 1'b1;
	end

	// Latch on the write strobe rise
	always @(posedge ctl.we_n) begin
		if (!ctl.ce_n && ctl.cle) begin
			na = 0;
			lc = io_in;
			case (io_in)
				8'h70: stat_md = 1'b1;
				8'h00: stat_md = 1'b0;
				8'h05: ;
				8'hE0: begin
					col = {hi[3:0], lo};
					stat_md = 1'b0;
					nrand++;
				end
				default: begin
					op = io_in;
					np = 0;
					stat_md = 1'b0;
				end
			endcase
		end else if (!ctl.ce_n && ctl.ale) begin
			if (na == 0)
				lo = io_in;
			else
				hi = io_in;
			na++;
			if (lc != 8'h05)
				fa = io_in;
			if ((lc == 8'hED || lc == 8'hEE) && na == 1) begin
				col = '0;
				-> go_busy;
			end
		end else if (!ctl.ce_n && op == 8'hEF && np < 4) begin
			plast[8 * np +: 8] = io_in;
			if (slot(fa) >= 0)
				feat[slot(fa)][8 * np +: 8] = io_in;
			np++;
			if (np == 4)
				-> go_busy;
		end
	end

	// One byte per read strobe; status reads do not advance
	always @(posedge ctl.re_n) begin
		if (!ctl.ce_n) begin
			last = ob;
			if (!stat_md)
				col++;
		end
	end
endmodule // nfh_flash_model

`default_nettype wire

//--- sim/nfh_host_monitor.sv
/*
 * Checker of the flash pins and read port of the host controller.
 * Assumes it is bound into nfh_host and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module nfh_host_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic sw_rd,
	input wire logic [31:0] sw_rdata,
	input wire nfh_pkg::nfh_ctl_t ctl,
	input wire logic [7:0] io_o,
	input wire logic io_oe,
	input wire logic rb_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	logic poll_r; // Status output selected inside a read operation
	logic [7:0] opc_r; // Opening command of the running operation

	// Track the latest command; a polled set-features has no data to return
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			poll_r <= 1'b0;
			opc_r <= 8'h00;
		end else if (ctl.cle && $rose(ctl.we_n)) begin
			poll_r <= (io_o == 8'h70) && (opc_r == 8'hED || opc_r == 8'hEE);
			if (io_o == 8'hED || io_o == 8'hEE || io_o == 8'hEF)
				opc_r <= io_o;
		end
	end

	sequence s_cmd(c);
		ctl.cle && !ctl.we_n && io_o == c ##1 ctl.we_n;
	endsequence
	sequence s_rd_pulse;
		!ctl.re_n [*3] ##1 ctl.re_n;
	endsequence

	AST_EXCL: assert property (
		!(ctl.cle && ctl.ale) && (ctl.we_n || ctl.re_n))
		else $error("latch enables or strobes overlap");
	AST_WE_PULSE: assert property (
		$fell(ctl.we_n) |=> $rose(ctl.we_n))
		else $error("write strobe not one cycle");
	AST_RE_PULSE: assert property (
		$fell(ctl.re_n) |-> s_rd_pulse)
		else $error("read strobe not three cycles");
	AST_WR_DRIVE: assert property (
		!ctl.we_n |-> io_oe)
		else $error("write strobe without driven data");
	AST_RD_FLOAT: assert property (
		!ctl.re_n |-> !io_oe)
		else $error("host drives bus during read");
	AST_WR_HOLD: assert property (
		!ctl.we_n |=> $stable(io_o) && $stable({ctl.cle, ctl.ale}))
		else $error("data moved before latch edge");
	AST_UID_ADDR: assert property (
		s_cmd(8'hED) |-> ##[1:20] (ctl.ale && !ctl.we_n && io_o == 8'h00))
		else $error("identifier command without 00h address");
	AST_ADL: assert property (
		ctl.ale && $rose(ctl.we_n) |-> ctl.we_n [*3])
		else $error("data follows address too soon");
	AST_POLL: assert property (
		poll_r && ctl.cle && $rose(ctl.we_n) |-> io_o == 8'h00 || io_o == 8'h70)
		else $error("status output not left through 00h");
	AST_BUSY: assert property (
		!rb_n && !ctl.we_n |-> ctl.cle && io_o == 8'h70)
		else $error("cycle other than status while busy");
	AST_RDATA: assert property (
		!$past(sw_rd) |-> sw_rdata == 32'h0)
		else $error("read data outside its cycle");
endmodule // nfh_host_monitor

bind nfh_host nfh_host_monitor nfh_host_monitor_inst (.clk(clk), .rst(rst), .sw_rd(sw_rd),
	.sw_rdata(sw_rdata), .ctl(ctl), .io_o(io_o), .io_oe(io_oe), .rb_n(rb_n));

`default_nettype wire

//--- sim/nfh_host_tb_top.sv
/*
 * Testbench of the feature and unique-ID host controller.
 * Assumes the package, design, flash model and checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module nfh_host_tb_top;
	logic clk, rst, sw_wr, sw_rd, rb_n, hang, bad, io_oe;
	logic [7:0] sw_addr, io_o, io_i, fl_dq;
	logic [31:0] sw_wdata, sw_rdata, rv;
	nfh_pkg::nfh_ctl_t ctl;
	int n_fail = 0;
	int num_checks = 0;

	// Host wins the bus while driving, else the flash
	assign io_i = io_oe ? io_o : fl_dq;
	always #50 clk = ~clk;

	nfh_host #(.TMO_CYC(50)) nfh_host_inst (.clk(clk), .rst(rst), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .ctl(ctl),
		.io_o(io_o), .io_oe(io_oe), .io_i(io_i), .rb_n(rb_n));
	nfh_flash_model nfh_flash_model_inst (.ctl(ctl), .io_in(io_o), .bad_copy(bad),
		.hang(hang), .dq(fl_dq), .rb_n(rb_n));

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Register port cycles, entered just after an edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		// Data stand for one cycle only; take them mid-cycle
		@(negedge clk);
		rv = sw_rdata;
		@(posedge clk);
	endtask

	// Start, try a refused address write, then poll until idle
	task automatic run(input logic [31:0] ctrl);
		wr(8'h00, ctrl);
		wr(8'h04, 32'h81);
		rd(8'h0C);
		chk("busy", rv, 32'h1);
		for (int i = 0; i < 3000 && rv[0] !== 1'b0; i++)
			rd(8'h0C);
	endtask

	task automatic t_regs;
		rd(8'h24);
		chk("unmapped", rv, 32'h0);
		// Empty operation: op and poll latch only with the start bit
		wr(8'h00, 32'hF);
		rd(8'h00);
		chk("ctrl", rv, 32'hE);
		rd(8'h0C);
		chk("idle", rv, 32'h0);
	endtask

	task automatic t_setf(input logic [7:0] fa, input logic [31:0] p, input logic poll);
		wr(8'h04, {24'h0, fa});
		wr(8'h08, p);
		run({28'h0, poll, 3'b011});
		// Done only; the ok flag belongs to an accepted identifier copy
		chk("setf status", rv, 32'h2);
		chk("params", nfh_flash_model_inst.plast, p);
	endtask

	// Address write skipped when the held address must be used
	task automatic t_getf(input logic [7:0] fa, input logic wfa, input logic [31:0] e,
		input logic poll);
		if (wfa)
			wr(8'h04, {24'h0, fa});
		run({28'h0, poll, 3'b101});
		chk("getf status", rv, 32'h2);
		rd(8'h10);
		chk("getdata", rv, e);
	endtask

	// A spoiled first copy must force one random data read
	task automatic t_uid(input logic b, input logic poll);
		int n0;
		n0 = nfh_flash_model_inst.nrand;
		bad <= b;
		run({28'h0, poll, 3'b001});
		chk("uid status", rv, 32'h6);
		chk("rand reads", 32'(nfh_flash_model_inst.nrand), 32'(n0 + int'(b)));
		for (int w = 0; w < 4; w++) begin
			rd(8'h14 + 8'(4 * w));
			chk("uid", rv, 32'hA3A2A1A0 + 32'h04040404 * 32'(w));
		end
	endtask

	// Stuck busy must end in the error flag
	task automatic t_hang;
		hang <= 1'b1;
		wr(8'h04, 32'h90);
		run(32'h5);
		chk("timeout", rv & 32'h9, 32'h8);
		hang <= 1'b0;
		repeat (250) @(posedge clk);
	endtask

	initial begin
		#5000000;
		n_fail++;
		end_of_test();
	end

	initial begin
		logic [7:0] codes [3];
		codes = '{8'h00, 8'h01, 8'h03};
		clk = 1'b0;
		rst = 1'b1;
		{sw_addr, sw_wdata, sw_wr, sw_rd, hang, bad} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		for (int i = 0; i < 3; i++) begin
			t_setf(8'h90, {24'h0, codes[i]}, i[0]);
			t_getf(8'h90, 1'b0, {24'h0, codes[i]}, ~i[0]);
		end
		t_setf(8'h01, 32'h2, 1'b0);
		t_setf(8'h42, 32'h5A5A5A5A, 1'b0);
		t_getf(8'h42, 1'b1, 32'h0, 1'b0);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_getf(8'h90, 1'b1, 32'h3, 1'b0);
		t_uid(1'b0, 1'b0);
		t_uid(1'b1, 1'b1);
		t_hang();
		end_of_test();
	end
endmodule // nfh_host_tb_top

`default_nettype wire
